// file: rtl/mcpc_top.sv
// media card parameter cloning controller with AHB-Lite register slave
// assumes the card agent answers each card_start with one card_done pulse
//
// Behaviour
// RQ1: a load copies parameters into working memory and internal nv store
// RQ2: a slot whose option category differs keeps its default menu
// RQ3: option module mismatch trips unless warnings are suppressed
// RQ4: voltage or current rating mismatch trips unless suppressed
// RQ5: rating parameters skipped on voltage mismatch, kept on current only
// RQ6: read mode plus reset loads block one, then mode clears and saves
// RQ7: auto mode plus reset writes all; later only menu 0 edits
// RQ8: auto mode writes advanced changes on save code or 1001 and reset
// RQ9: card removal while auto forces cloning mode to idle
// RQ10: power up in auto writes full set with unit leds flashing
// RQ11: in auto an internal parameter save also updates the card
// RQ12: auto writes overwrite an existing block without error
// RQ13: auto setting saved internally, not written to the card
// RQ14: boot power up loads only with card, block one, type 1-4, boot
// RQ15: boot load with drive mode mismatch trips and transfers nothing
// RQ16: boot setting goes to the card but is never read back
// RQ17: code 2001 plus reset builds bootable block one once
// RQ18: compare clears the command on match, trips on mismatch
// RQ19: erase code removes the named card block
// RQ20: 9666 sets and 9555 clears the warning suppression flag
// RQ21: read-only card blocks writes with a trip; only loads and 9777 act
// RQ22: undefined command values start nothing; a 4-bit thousands digit makes 20000-20999 start a block write
`timescale 1ns/1ns
module mcpc_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // drive events
  input  wire logic                drive_reset,
  input  wire logic                power_up,
  input  wire logic                param_saved,
  input  wire logic                menu0_changed,
  input  wire logic                card_present,
  // card agent request
  output logic                     card_start,
  output mcpc_pkg::mcpc_op_t       card_op,
  output logic      [9:0]          card_block,
  output logic                     card_incl_mode,
  output logic                     card_skip_opt,
  output logic                     card_skip_rating,
  // card agent answer
  input  wire logic                card_done,
  input  wire logic                card_ok,
  input  wire logic                card_match,
  input  wire logic                card_opt_diff,
  input  wire logic                card_volt_diff,
  input  wire logic                card_curr_diff,
  input  wire logic                card_mode_diff,
  input  wire logic [2:0]          card_blk_type,
  input  wire logic                card_boot,
  // drive side outputs
  output logic                     nv_store,
  output logic                     led_flash,
  output logic [mcpc_pkg::TRIP_W-1:0] trip_flags
);
  mcpc_pkg::mcpc_st_t         st_reg;
  mcpc_pkg::mcpc_op_t         g_op;
  logic [15:0]                cmd_reg;
  logic [2:0]                 mode_reg;
  logic                       sup_reg, ro_reg, bt_reg, pm_reg, pc_reg;
  logic                       a_vld, a_wr;
  logic [ADDR_W-1:0]          a_adr;
  logic [3:0]                 cdig;
  logic [9:0]                 cblk, g_blk;
  logic                       acc, wr_cmd, wr_mode, wr_trip, auto_like;
  logic                       go, g_fl, g_bt, g_pm, g_pc, ld, fin;
  logic                       cclr, mclr, nvs, ig_ro, sup_s, sup_c, ro_s, ro_c;
  logic [mcpc_pkg::TRIP_W-1:0] tset;
  logic [31:0]                rd_val;

  function automatic logic is_wr(mcpc_pkg::mcpc_op_t op);
    return op inside {mcpc_pkg::OP_WRITE, mcpc_pkg::OP_WRITE_M0,
                      mcpc_pkg::OP_ERASE, mcpc_pkg::OP_BOOT};
  endfunction

  assign cdig = 4'(cmd_reg / mcpc_pkg::K_DEC);
  assign cblk = 10'(cmd_reg % mcpc_pkg::K_DEC);
  assign auto_like = (mode_reg == mcpc_pkg::M_AUTO) ||
                     (mode_reg == mcpc_pkg::M_BOOT);
  assign acc = hsel && hready && htrans[1];
  assign wr_cmd  = a_vld && a_wr && (a_adr == mcpc_pkg::A_CMD);
  assign wr_mode = a_vld && a_wr && (a_adr == mcpc_pkg::A_MODE) &&
                   (hwdata[31:3] == 29'h0) &&
                   (hwdata[2:0] <= mcpc_pkg::M_BOOT);
  assign wr_trip = a_vld && a_wr && (a_adr == mcpc_pkg::A_TRIP);
  assign ig_ro = ro_reg && (cmd_reg != mcpc_pkg::C_CLR_RO);

  // request selection in idle, outcome handling on card_done
  always_comb begin
    go = 1'b0;
    g_op = mcpc_pkg::OP_CHECK;
    g_blk = mcpc_pkg::BLK_ONE;
    {g_fl, g_bt, g_pm, g_pc} = 4'h0;
    {ld, fin, cclr, mclr, nvs} = 5'h00;
    tset = '0;
    {sup_s, sup_c, ro_s, ro_c} = 4'h0;
    if (st_reg == mcpc_pkg::ST_IDLE) begin
      if (power_up && mode_reg == mcpc_pkg::M_AUTO) begin
        go = 1'b1; // RQ10
        g_op = mcpc_pkg::OP_WRITE;
        g_fl = 1'b1;
      end else if (power_up && mode_reg == mcpc_pkg::M_BOOT &&
                   card_present) begin
        go = 1'b1; // RQ14
        g_fl = 1'b1;
        g_bt = 1'b1;
      end else if (drive_reset && cmd_reg != 16'h0000) begin
        g_pc = 1'b1;
        if (cmd_reg == mcpc_pkg::C_BOOT) begin
          go = 1'b1; // RQ17
          g_op = mcpc_pkg::OP_BOOT;
        end else if ((cmd_reg == mcpc_pkg::C_SAVE ||
                      cmd_reg == mcpc_pkg::C_SAVE_TXT) && auto_like) begin
          go = 1'b1; // RQ8
          g_op = mcpc_pkg::OP_WRITE;
        end else if (cmd_reg == mcpc_pkg::C_SET_SUP && !ig_ro) begin
          sup_s = 1'b1; // RQ20
          cclr = 1'b1;
        end else if (cmd_reg == mcpc_pkg::C_CLR_SUP && !ig_ro) begin
          sup_c = 1'b1; // RQ20
          cclr = 1'b1;
        end else if (cmd_reg == mcpc_pkg::C_SET_RO && !ig_ro) begin
          ro_s = 1'b1;
          cclr = 1'b1;
        end else if (cmd_reg == mcpc_pkg::C_CLR_RO) begin
          ro_c = 1'b1; // RQ21
          cclr = 1'b1;
        end else if (cdig == mcpc_pkg::D_WRITE) begin
          go = 1'b1;
          g_op = mcpc_pkg::OP_WRITE;
          g_blk = cblk;
        end else if (cdig == mcpc_pkg::D_LOAD) begin
          go = 1'b1; // RQ1
          g_blk = cblk;
        end else if (cdig == mcpc_pkg::D_ERASE) begin
          go = 1'b1; // RQ19
          g_op = mcpc_pkg::OP_ERASE;
          g_blk = cblk;
        end else if (cdig == mcpc_pkg::D_CMP && !ro_reg) begin
          go = 1'b1; // RQ18
          g_op = mcpc_pkg::OP_COMPARE;
          g_blk = cblk;
        end
        // other values fall through untouched RQ22
      end else if (drive_reset && mode_reg == mcpc_pkg::M_READ) begin
        go = 1'b1; // RQ6
        g_pm = 1'b1;
      end else if (drive_reset && mode_reg == mcpc_pkg::M_PROG) begin
        go = 1'b1;
        g_op = mcpc_pkg::OP_WRITE;
        g_pm = 1'b1;
      end else if ((drive_reset || param_saved) && auto_like) begin
        go = 1'b1; // RQ7 RQ11 RQ12
        g_op = mcpc_pkg::OP_WRITE;
      end else if (menu0_changed && auto_like) begin
        go = 1'b1; // RQ7
        g_op = mcpc_pkg::OP_WRITE_M0;
      end
      if (go && ro_reg && is_wr(g_op)) begin
        go = 1'b0; // RQ21
        tset[mcpc_pkg::T_RDO] = 1'b1;
      end
    end else if (card_done) begin
      fin = 1'b1;
      unique case (card_op)
        mcpc_pkg::OP_CHECK: begin
          if (bt_reg && !(card_ok && card_boot &&
              card_blk_type >= mcpc_pkg::TYPE_MIN &&
              card_blk_type <= mcpc_pkg::TYPE_MAX)) begin
            fin = 1'b1; // RQ14
          end else if (!card_ok) begin
            fin = 1'b1;
          end else if (bt_reg && card_mode_diff) begin
            tset[mcpc_pkg::T_TYP] = 1'b1; // RQ15
          end else if ((card_opt_diff || card_volt_diff ||
                        card_curr_diff) && !sup_reg) begin
            tset[mcpc_pkg::T_OPT] = card_opt_diff; // RQ3
            tset[mcpc_pkg::T_RTG] = card_volt_diff || card_curr_diff; // RQ4
          end else begin
            fin = 1'b0;
            ld = 1'b1;
          end
        end
        mcpc_pkg::OP_LOAD: begin
          nvs = card_ok; // RQ1 RQ6
          cclr = card_ok && pc_reg;
          mclr = card_ok && pm_reg; // RQ6
        end
        mcpc_pkg::OP_COMPARE: begin
          cclr = card_ok && card_match && pc_reg; // RQ18
          tset[mcpc_pkg::T_CPR] = !(card_ok && card_match); // RQ18
        end
        default: begin
          cclr = card_ok && pc_reg;
          mclr = card_ok && pm_reg;
        end
      endcase
    end
  end

  // card request sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= mcpc_pkg::ST_IDLE;
      card_start <= 1'b0;
      card_op <= mcpc_pkg::OP_CHECK;
      card_block <= 10'h000;
      card_incl_mode <= 1'b0;
      card_skip_opt <= 1'b0;
      card_skip_rating <= 1'b0;
      led_flash <= 1'b0;
      bt_reg <= 1'b0;
      pm_reg <= 1'b0;
      pc_reg <= 1'b0;
    end else begin
      card_start <= 1'b0;
      if (go) begin
        st_reg <= mcpc_pkg::ST_WAIT;
        card_start <= 1'b1;
        card_op <= g_op;
        card_block <= g_blk;
        card_incl_mode <= is_wr(g_op) &&
                          mode_reg == mcpc_pkg::M_BOOT; // RQ13 RQ16
        card_skip_opt <= 1'b0;
        card_skip_rating <= 1'b0;
        led_flash <= g_fl;
        bt_reg <= g_bt;
        pm_reg <= g_pm;
        pc_reg <= g_pc;
      end else if (ld) begin
        card_start <= 1'b1;
        card_op <= mcpc_pkg::OP_LOAD;
        card_incl_mode <= 1'b0; // RQ16
        card_skip_opt <= card_opt_diff; // RQ2
        card_skip_rating <= card_volt_diff; // RQ5
      end else if (fin) begin
        st_reg <= mcpc_pkg::ST_IDLE;
        led_flash <= 1'b0;
      end
    end
  end

  // parameter and flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_reg <= 16'h0000;
      mode_reg <= mcpc_pkg::M_NONE;
      sup_reg <= 1'b0;
      ro_reg <= 1'b0;
      trip_flags <= '0;
      nv_store <= 1'b0;
    end else begin
      if (wr_cmd)
        cmd_reg <= hwdata[15:0];
      else if (cclr)
        cmd_reg <= 16'h0000;
      if (mclr || (!card_present && mode_reg == mcpc_pkg::M_AUTO))
        mode_reg <= mcpc_pkg::M_NONE; // RQ9
      else if (wr_mode)
        mode_reg <= hwdata[2:0];
      nv_store <= nvs || wr_mode; // RQ13
      if (sup_s || sup_c)
        sup_reg <= sup_s;
      if (ro_s || ro_c)
        ro_reg <= ro_s;
      trip_flags <= (trip_flags & ~(wr_trip ? hwdata[4:0] : 5'h00)) | tset;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (a_adr)
      mcpc_pkg::A_CMD:  rd_val[15:0] = cmd_reg;
      mcpc_pkg::A_MODE: rd_val[2:0] = mode_reg;
      mcpc_pkg::A_STAT: rd_val[4:0] = {st_reg == mcpc_pkg::ST_WAIT,
                                       led_flash, card_present, ro_reg,
                                       sup_reg};
      mcpc_pkg::A_TRIP: rd_val[4:0] = trip_flags;
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  // bus slave: one wait state per transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld <= 1'b0;
      a_wr <= 1'b0;
      a_adr <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (acc) begin
      a_vld <= 1'b1;
      a_wr <= hwrite;
      a_adr <= {haddr[ADDR_W-1:2], 2'b00};
      hreadyout <= 1'b0;
    end else if (a_vld) begin
      a_vld <= 1'b0;
      hreadyout <= 1'b1;
      if (!a_wr)
        hrdata <= rd_val;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic idle_now;
  assign idle_now = st_reg == mcpc_pkg::ST_IDLE;

  ro_block_a: assert property (idle_now && drive_reset && ro_reg && // RQ21
    !power_up && cmd_reg == mcpc_pkg::C_BOOT |=> trip_flags[4] && !card_start)
    else $error("write on read-only card did not trip");
  load_nv_a: assert property (!idle_now && card_done && card_ok && // RQ1
    card_op == mcpc_pkg::OP_LOAD |=> nv_store ##1 !nv_store || wr_mode)
    else $error("successful load did not store to nv");
  cmp_clear_a: assert property (!idle_now && card_done && card_ok && // RQ18
    card_match && card_op == mcpc_pkg::OP_COMPARE && pc_reg && !wr_cmd
    |=> cmd_reg == 16'h0000 && idle_now)
    else $error("compare match did not clear command");
  cmp_trip_a: assert property (!idle_now && card_done && // RQ18
    !card_match && card_op == mcpc_pkg::OP_COMPARE |=> trip_flags[3])
    else $error("compare mismatch did not trip");
  card_gone_a: assert property (!card_present && // RQ9
    mode_reg == mcpc_pkg::M_AUTO |=> mode_reg == mcpc_pkg::M_NONE)
    else $error("auto mode kept after card removal");
  sup_set_a: assert property (idle_now && drive_reset && !ro_reg && // RQ20
    !power_up && cmd_reg == mcpc_pkg::C_SET_SUP |=> sup_reg && !card_start)
    else $error("suppression flag not set");
  opt_trip_a: assert property (!idle_now && card_done && card_ok && // RQ3
    card_op == mcpc_pkg::OP_CHECK && !bt_reg && card_opt_diff && !sup_reg
    |=> trip_flags[0] && !card_start && idle_now)
    else $error("option mismatch did not trip");
  skip_rtg_a: assert property (!idle_now && card_done && card_ok && // RQ5
    card_op == mcpc_pkg::OP_CHECK && !bt_reg && sup_reg
    |=> card_start && card_op == mcpc_pkg::OP_LOAD &&
        card_skip_rating == $past(card_volt_diff))
    else $error("rating skip wrong on load");
  boot_type_a: assert property (!idle_now && card_done && bt_reg && // RQ14
    card_op == mcpc_pkg::OP_CHECK && !(card_blk_type inside {[3'h1:3'h4]})
    |=> !card_start && idle_now ##1 !card_start)
    else $error("boot load started on bad block type");
  typ_trip_a: assert property (!idle_now && card_done && bt_reg && // RQ15
    card_ok && card_boot && card_blk_type inside {[3'h1:3'h4]} &&
    card_mode_diff &&
    card_op == mcpc_pkg::OP_CHECK |=> trip_flags[2] && !card_start)
    else $error("boot mode mismatch did not trip");
  bus_wait_a: assert property (acc |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");

  load_c: cover property (card_start && card_op == mcpc_pkg::OP_LOAD);
  cmp_fail_c: cover property (tset[3]);
  boot_load_c: cover property (card_start && bt_reg &&
    card_op == mcpc_pkg::OP_LOAD);
endmodule // mcpc_top

// file: rtl/mcpc_pkg.sv
// constants and types for the media card parameter cloning controller
// assumes a 32-bit AHB-Lite register bus and word-aligned registers
package mcpc_pkg;
  // register byte offsets
  localparam logic [11:0] A_CMD  = 12'h000;
  localparam logic [11:0] A_MODE = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_TRIP = 12'h00c;
  // cloning mode values
  localparam logic [2:0] M_NONE = 3'h0;
  localparam logic [2:0] M_READ = 3'h1;
  localparam logic [2:0] M_PROG = 3'h2;
  localparam logic [2:0] M_AUTO = 3'h3;
  localparam logic [2:0] M_BOOT = 3'h4;
  // command entry values (decimal codes held in binary)
  localparam logic [15:0] C_SAVE_TXT = 16'h03e8;
  localparam logic [15:0] C_SAVE     = 16'h03e9;
  localparam logic [15:0] C_BOOT     = 16'h07d1;
  localparam logic [15:0] C_CLR_SUP  = 16'h2553;
  localparam logic [15:0] C_SET_SUP  = 16'h25c2;
  localparam logic [15:0] C_CLR_RO   = 16'h2631;
  localparam logic [15:0] C_SET_RO   = 16'h26a0;
  localparam logic [15:0] K_DEC      = 16'h03e8;
  // thousands digit of block commands
  localparam logic [3:0] D_WRITE = 4'h4;
  localparam logic [3:0] D_LOAD  = 4'h6;
  localparam logic [3:0] D_ERASE = 4'h7;
  localparam logic [3:0] D_CMP   = 4'h8;
  localparam logic [9:0] BLK_ONE = 10'h001;
  // trip bit positions
  localparam int T_OPT = 0;
  localparam int T_RTG = 1;
  localparam int T_TYP = 2;
  localparam int T_CPR = 3;
  localparam int T_RDO = 4;
  localparam int TRIP_W = 5;
  // status bit positions
  localparam int S_SUP   = 0;
  localparam int S_RO    = 1;
  localparam int S_CARD  = 2;
  localparam int S_FLASH = 3;
  localparam int S_BUSY  = 4;
  // boot block type range
  localparam logic [2:0] TYPE_MIN = 3'h1;
  localparam logic [2:0] TYPE_MAX = 3'h4;
  typedef enum logic [2:0] {
    OP_CHECK, OP_LOAD, OP_WRITE, OP_WRITE_M0, OP_ERASE, OP_COMPARE, OP_BOOT
  } mcpc_op_t;
  typedef enum logic {ST_IDLE, ST_WAIT} mcpc_st_t;
endpackage

// file: tb/mcpc_card_model.sv
// behavioural media card agent facing the cloning controller
// assumes one request at a time; the bench picks the answer profile
`timescale 1ns/1ns
module mcpc_card_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // request and answer profile
  input  wire logic       card_start,
  input  wire logic [6:0] prof,
  input  wire logic [2:0] prof_type,
  input  wire logic [3:0] dly,
  // answer to the controller
  output logic            card_done,
  output logic            card_ok,
  output logic            card_match,
  output logic            card_opt_diff,
  output logic            card_volt_diff,
  output logic            card_curr_diff,
  output logic            card_mode_diff,
  output logic [2:0]      card_blk_type,
  output logic            card_boot
);
  logic [3:0] cnt;
  logic       pend;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend      <= 1'b0;
      cnt       <= 4'h0;
      card_done <= 1'b0;
    end else begin
      card_done <= 1'b0;
      if (card_start) begin
        pend <= 1'b1;
        cnt  <= dly;
      end else if (pend && cnt == 4'h0) begin
        pend      <= 1'b0;
        card_done <= 1'b1;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // answer fields are only meaningful in the done cycle
  assign {card_ok, card_match, card_opt_diff, card_volt_diff,
          card_curr_diff, card_mode_diff, card_boot} =
         card_done ? prof : ~prof;
  assign card_blk_type = card_done ? prof_type : ~prof_type;
endmodule // mcpc_card_model

// file: tb/mcpc_top_tb_top.sv
// self-checking bench for the cloning controller and its card agent
// assumes one-wait-state slave answers and pulse events
`timescale 1ns/1ns
module mcpc_top_tb_top;
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout;
  logic                hresp, card_present, card_start, card_done;
  logic [31:0]         haddr, hwdata, hrdata, seq, rv;
  logic [1:0]          htrans, skp;
  logic [3:0]          ev, dly;
  logic [6:0]          prof;
  logic [2:0]          ptype, card_blk_type;
  logic [9:0]          card_block, blk;
  logic                card_incl_mode, card_skip_opt, card_skip_rating;
  logic                card_ok, card_match, card_opt_diff, card_boot;
  logic                card_volt_diff, card_curr_diff, card_mode_diff;
  logic                nv_store, led_flash, inc, fl;
  logic [4:0]          trip_flags;
  mcpc_pkg::mcpc_op_t  card_op;
  int                  miscompares, n_tests, nvc;
  assign hready = hreadyout;
  mcpc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .drive_reset(ev[0]),
    .power_up(ev[1]), .param_saved(ev[2]), .menu0_changed(ev[3]),
    .card_present(card_present), .card_start(card_start),
    .card_op(card_op), .card_block(card_block),
    .card_incl_mode(card_incl_mode), .card_skip_opt(card_skip_opt),
    .card_skip_rating(card_skip_rating), .card_done(card_done),
    .card_ok(card_ok), .card_match(card_match),
    .card_opt_diff(card_opt_diff), .card_volt_diff(card_volt_diff),
    .card_curr_diff(card_curr_diff), .card_mode_diff(card_mode_diff),
    .card_blk_type(card_blk_type), .card_boot(card_boot),
    .nv_store(nv_store), .led_flash(led_flash), .trip_flags(trip_flags));
  mcpc_card_model card (.hclk(hclk), .hresetn(hresetn),
    .card_start(card_start), .prof(prof), .prof_type(ptype), .dly(dly),
    .card_done(card_done), .card_ok(card_ok), .card_match(card_match),
    .card_opt_diff(card_opt_diff), .card_volt_diff(card_volt_diff),
    .card_curr_diff(card_curr_diff), .card_mode_diff(card_mode_diff),
    .card_blk_type(card_blk_type), .card_boot(card_boot));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // record every card request as one nibble of op code plus one
  always @(posedge hclk) begin
    if (card_start === 1'b1) begin
      seq <= (seq << 4) + 32'(card_op) + 32'h1;
      blk <= card_block;
      inc <= card_incl_mode;
      skp <= {card_skip_opt, card_skip_rating};
    end
    if (nv_store === 1'b1) nvc <= nvc + 1;
    if (led_flash === 1'b1) fl <= 1'b1;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50) begin
      @(posedge hclk);
      i++;
    end
    if (i == 50) chk("bus answer", 32'h0, 32'h1);
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic trips(input logic [31:0] e);
    rd(mcpc_pkg::A_TRIP);
    chk("trip flags", e, rv);
    chk("trip pins", e, {27'h0, trip_flags});
    chk("hresp okay", 32'h0, {31'h0, hresp});
    wr(mcpc_pkg::A_TRIP, 32'h1f);
  endtask
  task automatic run(input logic [15:0] c, input int e,
                     input logic [31:0] es);
    int i;
    i = 0;
    if (c !== 16'h0) wr(mcpc_pkg::A_CMD, {16'h0, c});
    seq = 32'h0;
    ev[e] <= 1'b1;
    @(posedge hclk);
    ev <= 4'h0;
    rd(mcpc_pkg::A_STAT);
    while (rv[mcpc_pkg::S_BUSY] !== 1'b0 && i < 100) begin
      rd(mcpc_pkg::A_STAT);
      i++;
    end
    if (i == 100) chk("busy end", 32'h0, 32'h1);
    chk("op sequence", es, seq);
  endtask
  task automatic t_flags;
    run(mcpc_pkg::C_SET_SUP, 0, 32'h0);
    chk("suppress on", 32'h1, 32'(rv[mcpc_pkg::S_SUP]));
    run(16'h0c33, 0, 32'h0);
    rd(mcpc_pkg::A_CMD);
    chk("unknown kept", 32'h0c33, rv);
    run(mcpc_pkg::C_CLR_SUP, 0, 32'h0);
    chk("suppress off", 32'h0, 32'(rv[mcpc_pkg::S_SUP]));
    $display("flags done");
  endtask
  task automatic t_load;
    nvc = 0;
    run(16'h1775, 0, 32'h12);
    chk("load block", 32'h5, {22'h0, blk});
    chk("nv save", 32'h1, 32'(nvc));
    rd(mcpc_pkg::A_CMD);
    chk("cmd cleared", 32'h0, rv);
    $display("load done");
  endtask
  task automatic t_mism;
    prof <= 7'h50;
    run(16'h1772, 0, 32'h1);
    trips(32'h1 << mcpc_pkg::T_OPT);
    prof <= 7'h48;
    run(16'h1772, 0, 32'h1);
    trips(32'h1 << mcpc_pkg::T_RTG);
    prof <= 7'h44;
    run(16'h1772, 0, 32'h1);
    trips(32'h1 << mcpc_pkg::T_RTG);
    run(mcpc_pkg::C_SET_SUP, 0, 32'h0);
    prof <= 7'h58;
    run(16'h1772, 0, 32'h12);
    chk("skips", 32'h3, {30'h0, skp});
    trips(32'h0);
    prof <= 7'h44;
    run(16'h1772, 0, 32'h12);
    chk("current only", 32'h0, {30'h0, skp});
    run(mcpc_pkg::C_CLR_SUP, 0, 32'h0);
    $display("mismatch done");
  endtask
  task automatic t_read;
    prof <= 7'h40;
    wr(mcpc_pkg::A_MODE, {29'h0, mcpc_pkg::M_READ});
    @(posedge hclk);
    nvc = 0;
    run(16'h0, 0, 32'h12);
    chk("read block", 32'h1, {22'h0, blk});
    chk("read saved", 32'h1, 32'(nvc));
    rd(mcpc_pkg::A_MODE);
    chk("mode idle", 32'h0, rv);
    $display("read mode done");
  endtask
  task automatic t_auto;
    dly <= 4'h6;
    nvc = 0;
    wr(mcpc_pkg::A_MODE, {29'h0, mcpc_pkg::M_AUTO});
    rd(mcpc_pkg::A_MODE);
    chk("auto stored", 32'h1, 32'(nvc));
    run(16'h0, 0, 32'h3);
    chk("no mode on card", 32'h0, 32'(inc));
    run(16'h0, 3, 32'h4);
    run(16'h0, 2, 32'h3);
    run(mcpc_pkg::C_SAVE, 0, 32'h3);
    fl = 1'b0;
    run(16'h0, 1, 32'h3);
    chk("leds flash", 32'h1, 32'(fl));
    trips(32'h0);
    card_present <= 1'b0;
    rd(mcpc_pkg::A_MODE);
    rd(mcpc_pkg::A_MODE);
    chk("auto dropped", 32'h0, rv);
    card_present <= 1'b1;
    dly <= 4'h1;
    $display("auto done");
  endtask
  task automatic t_boot;
    wr(mcpc_pkg::A_MODE, {29'h0, mcpc_pkg::M_BOOT});
    prof <= 7'h41;
    run(16'h0, 1, 32'h12);
    rd(mcpc_pkg::A_MODE);
    chk("mode not read", 32'h4, rv);
    ptype <= 3'h5;
    run(16'h0, 1, 32'h1);
    ptype <= 3'h2;
    prof <= 7'h40;
    run(16'h0, 1, 32'h1);
    prof <= 7'h43;
    run(16'h0, 1, 32'h1);
    trips(32'h1 << mcpc_pkg::T_TYP);
    card_present <= 1'b0;
    run(16'h0, 1, 32'h0);
    card_present <= 1'b1;
    run(16'h0, 2, 32'h3);
    chk("mode on card", 32'h1, 32'(inc));
    wr(mcpc_pkg::A_MODE, 32'h0);
    $display("boot done");
  endtask
  task automatic t_cmds;
    prof <= 7'h60;
    run(mcpc_pkg::C_BOOT, 0, 32'h7);
    chk("boot block", 32'h1, {22'h0, blk});
    run(16'h1b64, 0, 32'h5);
    chk("erase block", 32'hc, {22'h0, blk});
    run(16'h1f43, 0, 32'h6);
    rd(mcpc_pkg::A_CMD);
    chk("compare ok", 32'h0, rv);
    prof <= 7'h40;
    run(16'h1f43, 0, 32'h6);
    rd(mcpc_pkg::A_CMD);
    chk("compare kept", 32'h1f43, rv);
    trips(32'h1 << mcpc_pkg::T_CPR);
    $display("commands done");
  endtask
  task automatic t_ro;
    run(mcpc_pkg::C_SET_RO, 0, 32'h0);
    chk("ro on", 32'h1, 32'(rv[mcpc_pkg::S_RO]));
    run(16'h0fa3, 0, 32'h0);
    run(mcpc_pkg::C_BOOT, 0, 32'h0);
    run(16'h1f43, 0, 32'h0);
    trips(32'h1 << mcpc_pkg::T_RDO);
    run(mcpc_pkg::C_SET_SUP, 0, 32'h0);
    chk("sup ignored", 32'h0, 32'(rv[mcpc_pkg::S_SUP]));
    run(16'h1773, 0, 32'h12);
    run(mcpc_pkg::C_CLR_RO, 0, 32'h0);
    chk("ro off", 32'h0, 32'(rv[mcpc_pkg::S_RO]));
    $display("read only done");
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, ev} = '0;
    {card_present, prof, ptype, dly} = {1'b1, 7'h40, 3'h2, 4'h1};
    {seq, nvc, fl, miscompares, n_tests} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_flags;
    t_load;
    t_mism;
    t_read;
    t_auto;
    t_boot;
    t_cmds;
    t_ro;
    wrap_up;
  end
  initial begin
    #160000;
    miscompares++;
    wrap_up;
  end
endmodule // mcpc_top_tb_top
